// [camera_video_timing_port.sv]
`timescale 1ns/1ps
module camera_video_timing_port #(
  parameter int LINE_TOTAL = 1922,
  parameter int FRAME_ROWS = 1248
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control pins
  input  wire logic        hard_reset_n,
  input  wire logic        power_down_in,
  input  wire logic        frame_exposure_enable,
  input  wire logic        exposure_start_n,
  // Decoded serial control bus accesses
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Host pixel clock in slave mode
  input  wire logic        ext_pixel_clk,
  // Sensor array
  input  wire logic [9:0]  array_data,
  output logic      [10:0] array_row,
  output logic      [10:0] array_col,
  output logic             array_reset,
  // Video port
  output logic             pclk_out,
  output logic             pclk_oe_n,
  output logic             line_valid,
  output logic             frame_sync,
  output logic      [9:0]  video_data,
  output logic             video_oe_n
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (LINE_TOTAL <= cvt_pkg::ARRAY_COLS || LINE_TOTAL > 2047) begin : g_lchk
    $error("LINE_TOTAL out of range");
  end
  if (FRAME_ROWS <= cvt_pkg::ARRAY_ROWS || FRAME_ROWS > 2047) begin : g_fchk
    $error("FRAME_ROWS out of range");
  end

  localparam logic [10:0] H_LIMIT = 11'(LINE_TOTAL);
  localparam logic [10:0] V_LIMIT = 11'(FRAME_ROWS);

  cvt_pkg::top_s state;
  cvt_pkg::top_s next_state;
  logic        full_rst;
  logic        run;
  logic        running;
  logic        cnt_clear;
  logic        rise;
  logic        fall;
  logic        tick;
  logic        zooming;
  logic        dpix_done;
  logic        h_adv;
  logic        v_adv;
  logic        h_wrap;
  logic        v_wrap;
  logic        in_win;
  logic        next_valid;
  logic [1:0]  skip;
  logic [10:0] h_lo;
  logic [10:0] h_hi;
  logic [10:0] v_lo;
  logic [10:0] v_hi;
  logic [10:0] out_w;
  logic [10:0] out_h;
  logic [16:0] lead_total;
  logic [9:0]  pix;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (full_rst);

  // ---------------------------------------------------------------
  // Pixel clock and array position
  // ---------------------------------------------------------------
  pixel_clock_divider u_div (
    .clk     (clk),
    .rst     (cnt_clear),
    .run     (run),
    .slave   (state.cfg.mode[cvt_pkg::MODE_SLV_BIT]),
    .ext_clk (ext_pixel_clk),
    .ratio   (state.cfg.clk_div[5:0]),
    .rise    (rise),
    .fall    (fall)
  );

  coordinate_stepper u_col (
    .clk     (clk),
    .rst     (cnt_clear),
    .advance (h_adv),
    .skip    (skip),
    .limit   (H_LIMIT),
    .pos     (array_col),
    .wrap    (h_wrap)
  );

  coordinate_stepper u_row (
    .clk     (clk),
    .rst     (cnt_clear),
    .advance (v_adv),
    .skip    (skip),
    .limit   (V_LIMIT),
    .pos     (array_row),
    .wrap    (v_wrap)
  );

  // ---------------------------------------------------------------
  // Control decode
  // ---------------------------------------------------------------
  always_comb begin
    full_rst = rst || !hard_reset_n ||
               state.cfg.mode[cvt_pkg::MODE_SRST_BIT];
    // Soft power-down freezes the counters but keeps every register
    run = !power_down_in && !state.cfg.mode[cvt_pkg::MODE_SPD_BIT];
    running = state.snap == cvt_pkg::st_live ||
              state.snap == cvt_pkg::st_readout;
    cnt_clear = full_rst || power_down_in || !running;
    tick = state.cfg.vpc[cvt_pkg::VPC_RISE_BIT] ? fall : rise;
    dpix_done = state.dpix >= {state.cfg.dpix_hi, state.cfg.dpix_lo};
    h_adv = tick && dpix_done && !cnt_clear;
    v_adv = h_wrap && !state.in_lead;
    lead_total = 17'(cvt_pkg::SYNC_LINES +
                     {state.cfg.dline_hi, state.cfg.dline_lo} +
                     {state.cfg.fadj_hi, state.cfg.fadj_lo});
    for (int i = 0; i < 10; i++) begin
      pix[i] = state.cfg.mode[cvt_pkg::MODE_SWAP_BIT] ?
               array_data[9-i] : array_data[i];
    end
  end

  // ---------------------------------------------------------------
  // Window and zoom
  // ---------------------------------------------------------------
  always_comb begin
    zooming = state.cfg.mode[cvt_pkg::MODE_ZOOM_BIT] &&
              (state.cfg.mode[1:0] == cvt_pkg::SKIP_MEDIUM ||
               state.cfg.mode[1:0] == cvt_pkg::SKIP_SMALL);
    if (state.cfg.mode[1:0] == cvt_pkg::SKIP_SMALL) begin
      out_w = cvt_pkg::SMALL_W;
      out_h = cvt_pkg::SMALL_H;
    end else begin
      out_w = cvt_pkg::MED_W;
      out_h = cvt_pkg::MED_H;
    end
    // Reserved mode 3 runs as full resolution
    skip = (zooming || state.cfg.mode[1:0] == 2'h3) ?
           cvt_pkg::SKIP_FULL : state.cfg.mode[1:0];
    h_lo = {state.cfg.wh_start, state.cfg.wh_ext[2:0]};
    h_hi = {state.cfg.wh_end, state.cfg.wh_ext[5:3]};
    v_lo = {state.cfg.wv_start, state.cfg.wv_ext[2:0]};
    v_hi = {state.cfg.wv_end, state.cfg.wv_ext[5:3]};
    if (zooming) begin
      // Full-rate crop of the output size gives the zoom ratio
      if (state.cfg.pan[cvt_pkg::PAN_H_BIT]) begin
        h_lo = 11'(h_lo + out_w);
      end
      h_hi = 11'(h_lo + out_w);
      v_lo = {1'b0, state.cfg.zoom_ext[1:0], state.cfg.zoom};
      v_hi = 11'(v_lo + out_h);
    end
    // Window gates only line_valid; line and frame lengths stay put
    in_win = array_col >= h_lo && array_col < h_hi &&
             array_row >= v_lo && array_row < v_hi;
    next_valid = !state.in_lead && dpix_done && in_win;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (reg_write) begin
      case (reg_addr)
        cvt_pkg::A_CLK_DIV:  next_state.cfg.clk_div  = reg_wdata;
        cvt_pkg::A_VPC:      next_state.cfg.vpc      = reg_wdata;
        cvt_pkg::A_MODE:     next_state.cfg.mode     = reg_wdata;
        cvt_pkg::A_DPIX_LO:  next_state.cfg.dpix_lo  = reg_wdata;
        cvt_pkg::A_DPIX_HI:  next_state.cfg.dpix_hi  = reg_wdata;
        cvt_pkg::A_DLINE_LO: next_state.cfg.dline_lo = reg_wdata;
        cvt_pkg::A_DLINE_HI: next_state.cfg.dline_hi = reg_wdata;
        cvt_pkg::A_FADJ_LO:  next_state.cfg.fadj_lo  = reg_wdata;
        cvt_pkg::A_FADJ_HI:  next_state.cfg.fadj_hi  = reg_wdata;
        cvt_pkg::A_WH_START: next_state.cfg.wh_start = reg_wdata;
        cvt_pkg::A_WH_END:   next_state.cfg.wh_end   = reg_wdata;
        cvt_pkg::A_WH_EXT:   next_state.cfg.wh_ext   = reg_wdata;
        cvt_pkg::A_WV_START: next_state.cfg.wv_start = reg_wdata;
        cvt_pkg::A_WV_END:   next_state.cfg.wv_end   = reg_wdata;
        cvt_pkg::A_WV_EXT:   next_state.cfg.wv_ext   = reg_wdata;
        cvt_pkg::A_PAN:      next_state.cfg.pan      = reg_wdata;
        cvt_pkg::A_ZOOM_EXT: next_state.cfg.zoom_ext = reg_wdata;
        cvt_pkg::A_ZOOM:     next_state.cfg.zoom     = reg_wdata;
        default: ;
      endcase
    end
    case (reg_addr)
      cvt_pkg::A_CLK_DIV:  next_state.rdata = state.cfg.clk_div;
      cvt_pkg::A_VPC:      next_state.rdata = state.cfg.vpc;
      cvt_pkg::A_MODE:     next_state.rdata = state.cfg.mode;
      cvt_pkg::A_STATUS:   next_state.rdata = {2'h0, state.frame_sync,
        state.line_valid, state.in_lead, state.snap};
      cvt_pkg::A_DPIX_LO:  next_state.rdata = state.cfg.dpix_lo;
      cvt_pkg::A_DPIX_HI:  next_state.rdata = state.cfg.dpix_hi;
      cvt_pkg::A_DLINE_LO: next_state.rdata = state.cfg.dline_lo;
      cvt_pkg::A_DLINE_HI: next_state.rdata = state.cfg.dline_hi;
      cvt_pkg::A_FADJ_LO:  next_state.rdata = state.cfg.fadj_lo;
      cvt_pkg::A_FADJ_HI:  next_state.rdata = state.cfg.fadj_hi;
      cvt_pkg::A_WH_START: next_state.rdata = state.cfg.wh_start;
      cvt_pkg::A_WH_END:   next_state.rdata = state.cfg.wh_end;
      cvt_pkg::A_WH_EXT:   next_state.rdata = state.cfg.wh_ext;
      cvt_pkg::A_WV_START: next_state.rdata = state.cfg.wv_start;
      cvt_pkg::A_WV_END:   next_state.rdata = state.cfg.wv_end;
      cvt_pkg::A_WV_EXT:   next_state.rdata = state.cfg.wv_ext;
      cvt_pkg::A_PAN:      next_state.rdata = state.cfg.pan;
      cvt_pkg::A_ZOOM_EXT: next_state.rdata = state.cfg.zoom_ext;
      cvt_pkg::A_ZOOM:     next_state.rdata = state.cfg.zoom;
      default:             next_state.rdata = 8'h00;
    endcase

    // Snapshot sequencing
    unique case (state.snap)
      cvt_pkg::st_live, cvt_pkg::st_readout, cvt_pkg::st_halted: begin
        if (frame_exposure_enable) begin
          next_state.snap = cvt_pkg::st_precharge;
        end else if (state.snap == cvt_pkg::st_readout && v_wrap) begin
          next_state.snap = state.cfg.mode[cvt_pkg::MODE_ONE_BIT] ?
            cvt_pkg::st_halted : cvt_pkg::st_live;
        end
      end
      cvt_pkg::st_precharge: begin
        if (!frame_exposure_enable) begin
          next_state.snap = cvt_pkg::st_readout;
        end else if (!exposure_start_n) begin
          next_state.snap = cvt_pkg::st_expose;
        end
      end
      cvt_pkg::st_expose: begin
        if (!frame_exposure_enable) begin
          next_state.snap = cvt_pkg::st_readout;
        end
      end
      default: next_state.snap = cvt_pkg::st_live;
    endcase
    next_state.array_reset =
      next_state.snap == cvt_pkg::st_precharge;

    // Line and frame sequencing; frames open with sync and dummy lines
    if (cnt_clear) begin
      next_state.dpix       = 16'h0000;
      next_state.lead       = 17'h00000;
      next_state.in_lead    = 1'b1;
      next_state.line_valid = 1'b0;
      next_state.frame_sync = 1'b0;
      next_state.video      = 10'h000;
    end else if (tick) begin
      if (!dpix_done) begin
        next_state.dpix = state.dpix + 16'h0001;
      end else if (h_wrap) begin
        next_state.dpix = 16'h0000;
        if (state.in_lead) begin
          next_state.lead = state.lead + 17'h00001;
          if (state.lead + 17'h00001 >= lead_total) begin
            next_state.in_lead = 1'b0;
          end
        end else if (v_wrap) begin
          next_state.in_lead = 1'b1;
          next_state.lead    = 17'h00000;
        end
      end
      next_state.line_valid = next_valid;
      next_state.video = next_valid ? pix : 10'h000;
      next_state.frame_sync = state.in_lead &&
                              state.lead < cvt_pkg::SYNC_LINES;
    end

    // Pixel clock pin
    if (cnt_clear || !run) begin
      next_state.pclk = 1'b0;
    end else if (rise) begin
      next_state.pclk = 1'b1;
    end else if (fall) begin
      next_state.pclk = 1'b0;
    end
    if (next_state.cfg.vpc[cvt_pkg::VPC_GATE_BIT] &&
        !next_state.line_valid) begin
      next_state.pclk = 1'b0;
    end
    next_state.video_oe_n = power_down_in;
    next_state.pclk_oe_n = power_down_in ||
                           state.cfg.mode[cvt_pkg::MODE_SLV_BIT];
  end

  always_ff @(posedge clk) begin
    if (full_rst) begin
      state     <= '0;
      state.cfg <= cvt_pkg::CFG_RESET;
      state.in_lead <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata   = state.rdata;
  assign array_reset = state.array_reset;
  assign pclk_out    = state.pclk;
  assign pclk_oe_n   = state.pclk_oe_n;
  assign line_valid  = state.line_valid;
  assign frame_sync  = state.frame_sync;
  assign video_data  = state.video;
  assign video_oe_n  = state.video_oe_n;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_SYNC_NOT_VALID: assert property (
    frame_sync |-> !line_valid)
    else $error("frame sync overlaps line valid");
  AST_LEAD_BLANK: assert property (
    state.in_lead && tick && !cnt_clear |=> !line_valid)
    else $error("line valid during dummy lines");
  AST_PD_CLEAR: assert property (
    power_down_in |=> array_col == 11'h000 && array_row == 11'h000
      && !pclk_out && video_oe_n)
    else $error("power-down left counters running");
  AST_GATE: assert property (
    state.cfg.vpc[cvt_pkg::VPC_GATE_BIT] && !line_valid |-> !pclk_out)
    else $error("gated pixel clock toggled outside active video");
  AST_PRECHARGE: assert property (
    frame_exposure_enable && running |=> array_reset ##1 array_reset)
    else $error("array not held in reset");
  AST_EXPOSE: assert property (
    state.snap == cvt_pkg::st_precharge && frame_exposure_enable
      && !exposure_start_n |=> !array_reset
      && state.snap == cvt_pkg::st_expose)
    else $error("exposure did not start");
  AST_READOUT: assert property (
    state.snap == cvt_pkg::st_expose && !frame_exposure_enable |=>
      state.snap == cvt_pkg::st_readout && array_row == 11'h000
      && state.in_lead)
    else $error("readout did not start at frame top");
  AST_SINGLE: assert property (
    state.snap == cvt_pkg::st_readout && v_wrap && !frame_exposure_enable
      && state.cfg.mode[cvt_pkg::MODE_ONE_BIT] |=>
      state.snap == cvt_pkg::st_halted ##1 !line_valid)
    else $error("single frame mode did not stop");
  AST_HARD_RESET: assert property (disable iff (rst)
    !hard_reset_n |=> state.cfg == cvt_pkg::CFG_RESET
      && state.snap == cvt_pkg::st_live)
    else $error("hard reset did not restore defaults");
  AST_BLANK_DATA: assert property (
    $fell(line_valid) |-> video_data == 10'h000)
    else $error("data left on port after line end");

  COV_FRAME: cover property (@(posedge clk) disable iff (full_rst)
    state.snap == cvt_pkg::st_live && v_wrap);
  COV_READOUT: cover property (@(posedge clk) disable iff (full_rst)
    state.snap == cvt_pkg::st_expose ##1 state.snap == cvt_pkg::st_readout);
  COV_HALT: cover property (@(posedge clk) disable iff (full_rst)
    state.snap == cvt_pkg::st_halted);
  COV_ZOOM: cover property (@(posedge clk) disable iff (full_rst)
    zooming && line_valid);

endmodule

// [coordinate_stepper.sv]
`timescale 1ns/1ps
module coordinate_stepper (
  // Clock and counter clear
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Stepping control
  input  wire logic                        advance,
  input  wire logic [1:0]                  skip,
  input  wire logic [cvt_pkg::COORD_W-1:0] limit,
  // Position
  output logic      [cvt_pkg::COORD_W-1:0] pos,
  output logic                             wrap
);

  cvt_pkg::stepper_s state;
  cvt_pkg::stepper_s next_state;
  logic [cvt_pkg::COORD_W:0] target;

  always_comb begin
    target = {1'b0, state.pos} + 12'h001;
    // Skipped pairs are never visited, so sub-sampled lines get shorter
    if (skip == cvt_pkg::SKIP_MEDIUM && state.pos[1:0] == 2'h1) begin
      target = {1'b0, state.pos} + 12'h003;
    end else if (skip == cvt_pkg::SKIP_SMALL && state.pos[2:0] == 3'h1) begin
      target = {1'b0, state.pos} + 12'h007;
    end
    wrap = advance && (target >= {1'b0, limit});
    next_state = state;
    if (advance) begin
      next_state.pos = wrap ? '0 : target[cvt_pkg::COORD_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pos = state.pos;

endmodule

// [cvt_pkg.sv]
// Summary of operation
// - Window programmable 2x4 to 1632x1220, default 1600x1200
// - Window moves only line_valid, never frame rate
// - Zoom/pan: 2:1 medium, 4:1 small only
// - Zoom vertical start 10 bits, pan bit 2
// - Medium mode outputs 800x600, both axes sub-sampled
// - Small mode outputs 400x296, faster frame rate
// - Exposure enable high precharges; start low exposes
// - Exposure enable low reads frame out line-wise
// - After snapshot frame: live, or stop if single
// - Prescaler divides pixel and frame rate 1/2..1/64
// - Dummy pixels per line slow frame rate
// - Dummy lines in vertical sync slow frame rate
// - Pixel clock scales linearly with frame rate
// - Hard or soft reset restores all register defaults
// - Hard power-down halts clock, clears all counters
// - Soft power-down suspends activity, keeps registers
// - 10-bit port, optional most/least bit swap
// - Master or slave; data tied to pixel clock
// - Data valid on falling edge; bit 4 rising
// - Bit 5 gates pixel clock to active video
// - Line order B,G then G,R from frame start
// - Medium mode keeps column pairs 0-1, 4-5, ...
package cvt_pkg;

  // ---------------------------------------------------------------
  // Geometry and timing
  // ---------------------------------------------------------------
  localparam int         COORD_W     = 11;
  localparam int         ARRAY_COLS  = 1632;
  localparam int         ARRAY_ROWS  = 1220;
  localparam logic [16:0] SYNC_LINES = 17'h00004;
  localparam logic [10:0] MED_W      = 11'h320;
  localparam logic [10:0] MED_H      = 11'h258;
  localparam logic [10:0] SMALL_W    = 11'h190;
  localparam logic [10:0] SMALL_H    = 11'h128;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CLK_DIV  = 8'h10;
  localparam logic [7:0] A_VPC      = 8'h11;
  localparam logic [7:0] A_MODE     = 8'h12;
  localparam logic [7:0] A_STATUS   = 8'h13;
  localparam logic [7:0] A_DPIX_LO  = 8'h14;
  localparam logic [7:0] A_DPIX_HI  = 8'h15;
  localparam logic [7:0] A_DLINE_LO = 8'h16;
  localparam logic [7:0] A_DLINE_HI = 8'h17;
  localparam logic [7:0] A_FADJ_LO  = 8'h18;
  localparam logic [7:0] A_FADJ_HI  = 8'h19;
  localparam logic [7:0] A_WH_START = 8'h1a;
  localparam logic [7:0] A_WH_END   = 8'h1b;
  localparam logic [7:0] A_WH_EXT   = 8'h1c;
  localparam logic [7:0] A_WV_START = 8'h1d;
  localparam logic [7:0] A_WV_END   = 8'h1e;
  localparam logic [7:0] A_WV_EXT   = 8'h1f;
  localparam logic [7:0] A_PAN      = 8'h34;
  localparam logic [7:0] A_ZOOM_EXT = 8'h48;
  localparam logic [7:0] A_ZOOM     = 8'h49;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int VPC_RISE_BIT  = 4;
  localparam int VPC_GATE_BIT  = 5;
  localparam int MODE_ZOOM_BIT = 2;
  localparam int MODE_ONE_BIT  = 3;
  localparam int MODE_SWAP_BIT = 4;
  localparam int MODE_SLV_BIT  = 5;
  localparam int MODE_SPD_BIT  = 6;
  localparam int MODE_SRST_BIT = 7;
  localparam int PAN_H_BIT     = 2;
  localparam logic [1:0] SKIP_FULL   = 2'h0;
  localparam logic [1:0] SKIP_MEDIUM = 2'h1;
  localparam logic [1:0] SKIP_SMALL  = 2'h2;

  typedef enum logic [2:0] {
    st_live, st_precharge, st_expose, st_readout, st_halted
  } snap_e;

  typedef struct packed {
    logic [7:0] clk_div, vpc, mode, dpix_lo, dpix_hi;
    logic [7:0] dline_lo, dline_hi, fadj_lo, fadj_hi;
    logic [7:0] wh_start, wh_end, wh_ext, wv_start, wv_end, wv_ext;
    logic [7:0] pan, zoom_ext, zoom;
  } cfg_s;

  // Default window: columns 16..1615, rows 10..1209
  localparam cfg_s CFG_RESET = '{
    wh_start: 8'h02, wh_end: 8'hca, wh_ext: 8'h00,
    wv_start: 8'h01, wv_end: 8'h97, wv_ext: 8'h12,
    default: 8'h00};

  typedef struct packed {
    cfg_s        cfg;
    snap_e       snap;
    logic [15:0] dpix;
    logic [16:0] lead;
    logic        in_lead, pclk, line_valid, frame_sync, array_reset;
    logic [9:0]  video;
    logic [7:0]  rdata;
    logic        video_oe_n, pclk_oe_n;
  } top_s;

  typedef struct packed {
    logic [COORD_W-1:0] pos;
  } stepper_s;

  typedef struct packed {
    logic [5:0] cnt;
    logic       ext_prev;
  } divider_s;

endpackage

// [host_capture_model.sv]
`timescale 1ns/1ps
module host_capture_model (
  // Array fetch
  input  wire logic [10:0] row,
  input  wire logic [10:0] col,
  output logic      [9:0]  pix,
  // Video port watch
  input  wire logic        clk,
  input  wire logic        frame_sync,
  output logic             sync_seen
);
  // Unique within each 32x32 block of sites so a wrong fetch shows
  assign pix = {row[4:0], col[4:0]} ^ 10'h2a5;
  always @(posedge clk) begin
    sync_seen <= (sync_seen === 1'b1) || frame_sync;
  end
endmodule

// [pixel_clock_divider.sv]
`timescale 1ns/1ps
module pixel_clock_divider (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic       slave,
  input  wire logic       ext_clk,
  input  wire logic [5:0] ratio,
  // Pixel clock phases
  output logic            rise,
  output logic            fall
);

  cvt_pkg::divider_s state;
  cvt_pkg::divider_s next_state;
  logic [5:0] last;
  logic [6:0] half;

  always_comb begin
    // Setting 0 behaves as 1, so the fastest rate is half the input
    last = (ratio == 6'h00) ? 6'h01 : ratio;
    half = 7'(({1'b0, last} + 7'h01) >> 1);
    if (slave) begin
      rise = run && ext_clk && !state.ext_prev;
      fall = run && !ext_clk && state.ext_prev;
    end else begin
      rise = run && state.cnt == 6'h00;
      fall = run && {1'b0, state.cnt} == half;
    end
    next_state.ext_prev = ext_clk;
    if (!run || state.cnt >= last) begin
      next_state.cnt = 6'h00;
    end else begin
      next_state.cnt = state.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, hrn = 1'b1, pd = 1'b0;
  logic        fxe = 1'b0, xs_n = 1'b1, wr = 1'b0, chk = 1'b0;
  logic        xc = 1'b0, gt = 1'b0;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rd_d, d;
  logic [7:0]  q_exp[$], q_msk[$];
  logic [10:0] row, col;
  logic [9:0]  ad, vd;
  logic        ar, pc, pc_oe, lv, fs, v_oe, seen;
  int          error_cnt = 0, cmp_count = 0, n;
  always #10 clk = ~clk;
  // Host clock for slave mode, two system clocks per period
  always @(negedge clk) xc <= ~xc;
  host_capture_model host_capture_model_i (.row(row), .col(col),
    .pix(ad), .clk(clk), .frame_sync(fs), .sync_seen(seen));
  camera_video_timing_port camera_video_timing_port_i (.clk(clk),
    .rst(rst), .hard_reset_n(hrn), .power_down_in(pd),
    .frame_exposure_enable(fxe), .exposure_start_n(xs_n),
    .reg_write(wr), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd_d),
    .ext_pixel_clk(xc), .array_data(ad), .array_row(row),
    .array_col(col), .array_reset(ar), .pclk_out(pc),
    .pclk_oe_n(pc_oe), .line_valid(lv), .frame_sync(fs),
    .video_data(vd), .video_oe_n(v_oe));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wd = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Expectation queued by the driver, checked by the watcher
  task automatic rreg(input logic [7:0] a, e, input logic [7:0] m);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    q_exp.push_back(e);
    q_msk.push_back(m);
    chk = 1'b1;
    @(negedge clk);
    chk = 1'b0;
  endtask
  always @(posedge clk) if (chk) begin
    cmp(rd_d & q_msk.pop_front(), q_exp.pop_front());
  end
  // Blanking must be quiet on the data lines
  always @(negedge clk) if (!rst && lv === 1'b0) begin
    cmp({pc & gt, vd}, 16'h0);
  end
  initial begin
    #1900000;
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(35));
    repeat (16) @(negedge clk);
    rst = 1'b0;
    wreg(cvt_pkg::A_MODE, 8'h10);
    wreg(cvt_pkg::A_VPC, 8'h20);
    gt = 1'b1;
    n = 0;
    while (lv !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    cmp(seen, 1'b1);
    cmp(vd, 16'h2bf);
    cmp(pc, 1'b1);
    n = 0;
    while (lv === 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    cmp(n[15:0], 16'hc80);
    $display("video test done");
    rreg(cvt_pkg::A_ZOOM, 8'h00, 8'hff);
    rreg(cvt_pkg::A_PAN, 8'h00, 8'hff);
    rreg(cvt_pkg::A_WH_START, 8'h02, 8'hff);
    d = 8'($urandom) | 8'h01;
    wreg(cvt_pkg::A_ZOOM, d);
    wreg(cvt_pkg::A_ZOOM_EXT, ~d);
    wreg(8'h7f, d);
    rreg(cvt_pkg::A_ZOOM, d, 8'hff);
    rreg(cvt_pkg::A_ZOOM_EXT, ~d, 8'hff);
    rreg(8'h7f, 8'h00, 8'hff);
    wreg(cvt_pkg::A_MODE, 8'h40);
    rreg(cvt_pkg::A_ZOOM, d, 8'hff);
    gt = 1'b0;
    wreg(cvt_pkg::A_MODE, 8'h80);
    rreg(cvt_pkg::A_ZOOM, 8'h00, 8'hff);
    wreg(cvt_pkg::A_PAN, d);
    hrn = 1'b0;
    repeat (2) @(negedge clk);
    hrn = 1'b1;
    rreg(cvt_pkg::A_PAN, 8'h00, 8'hff);
    $display("register test done");
    pd = 1'b1;
    repeat (3) @(negedge clk);
    cmp({pc_oe, v_oe, pc}, 16'h6);
    pd = 1'b0;
    fxe = 1'b1;
    repeat (2) @(negedge clk);
    cmp(ar, 1'b1);
    rreg(cvt_pkg::A_STATUS, 8'h01, 8'h07);
    xs_n = 1'b0;
    repeat (2) @(negedge clk);
    cmp(ar, 1'b0);
    rreg(cvt_pkg::A_STATUS, 8'h02, 8'h07);
    fxe = 1'b0;
    rreg(cvt_pkg::A_STATUS, 8'h03, 8'h07);
    wreg(cvt_pkg::A_MODE, 8'h20);
    @(negedge clk);
    cmp(pc_oe, 1'b1);
    $display("snapshot test done");
    results();
  end
endmodule
